// *** rtl/tdfe_pkg.sv ***
// Shared constants and carrier types for the tone detector front end.
// Assumes one 10 MHz core clock and a word-aligned register port.
package tdfe_pkg;
  // Clock rate, for anyone deriving timing figures
  localparam int unsigned CLK_HZ = 10_000_000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_EDF      = 8'h04;
  localparam logic [7:0] OFS_THR_ON   = 8'h08;
  localparam logic [7:0] OFS_THR_OFF  = 8'h0C;
  localparam logic [7:0] OFS_FLT_LEN  = 8'h10;
  localparam logic [7:0] OFS_FLT_WID  = 8'h14;
  localparam logic [7:0] OFS_FLT_SEL  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;
  localparam logic [7:0] OFS_MASK     = 8'h20;
  localparam logic [7:0] OFS_DIGIT    = 8'h24;
  localparam logic [7:0] OFS_ARRIVAL  = 8'h28;
  localparam logic [7:0] OFS_DEPART   = 8'h2C;
  localparam logic [7:0] OFS_CUR_TIME = 8'h30;
  localparam logic [7:0] OFS_ENVELOPE = 8'h34;
  localparam logic [7:0] OFS_STATE    = 8'h38;

  // Control register fields
  localparam int CTRL_MULAW  = 0;
  localparam int CTRL_GAIN_L = 1;
  localparam int CTRL_DTMF   = 3;
  localparam int CTRL_TONE   = 4;

  // Status and mask bit positions
  localparam int ST_DIGIT  = 0;
  localparam int ST_SHORT  = 1;
  localparam int ST_DEPART = 2;
  localparam int ST_ONSET  = 3;
  localparam int ST_DROP   = 4;
  localparam int ST_W      = 5;

  // Reset values
  localparam logic [15:0] RST_EDF     = 16'h0040;
  localparam logic [15:0] RST_THR_ON  = 16'h0400;
  localparam logic [15:0] RST_THR_OFF = 16'h0200;
  localparam logic [10:0] RST_FLT_LEN = 11'h03D;
  localparam logic [8:0]  RST_FLT_WID = 9'h000;
  localparam logic [8:0]  MAX_FLT_WID = 9'h1EC;

  // Companding expansion constants
  localparam logic [7:0]  ALAW_XOR  = 8'h55;
  localparam logic [15:0] MU_BIAS   = 16'h0084;
  localparam logic [15:0] ALAW_STEP = 16'h0100;

  // Gain shifts: top of range at +2, -10, -22 dBm0
  localparam logic [2:0] GAIN_SH_P2  = 3'h0;
  localparam logic [2:0] GAIN_SH_M10 = 3'h2;
  localparam logic [2:0] GAIN_SH_M22 = 3'h4;

  // Envelope arithmetic
  localparam int ENV_FRAC  = 15;
  localparam int ENV_SCALE = 5;

  // Digit tolerance in tenths of a percent, and power spread in dB
  localparam logic [15:0] TOL_PERMILLE = 16'h0013;
  localparam logic [15:0] PERMILLE     = 16'h03E8;
  localparam logic [7:0]  MAX_SPREAD   = 8'h0A;

  // Nominal tone frequencies in Hz
  localparam logic [11:0] LOW_HZ  [4] = '{12'h2B9, 12'h302, 12'h354, 12'h3AD};
  localparam logic [11:0] HIGH_HZ [4] = '{12'h4B9, 12'h538, 12'h5C5, 12'h661};

  // Power detector outcomes
  typedef enum logic [3:0] {
    TDFE_ONSET  = 4'b0001,
    TDFE_DEPART = 4'b0010,
    TDFE_TONE   = 4'b0100,
    TDFE_QUIET  = 4'b1000
  } tdfe_class_t;

  // Digit candidate from the bandpass filter bank
  typedef struct packed {
    logic        valid;
    logic [11:0] low_hz;
    logic [11:0] high_hz;
    logic [7:0]  low_db;
    logic [7:0]  high_db;
  } tdfe_cand_t;

  // Processed sample handed on to the filters
  typedef struct packed {
    logic               valid;
    logic               to_dtmf;
    logic signed [15:0] value;
  } tdfe_proc_t;
endpackage : tdfe_pkg

// *** rtl/tdfe_top.sv ***
// Tone detector front end: sample queue, expansion, gain, envelope detector,
// digit validation, filter bank settings and host registers with interrupt.
// Assumes samples and candidates arrive synchronous to core_clk_in.
//
// Behaviour
// - Queue up to eight samples, one per step
// - Input and host first; pause during block work
// - Expand A-law by default, mu-law optionally
// - Three gain choices: +2, -10, -22 dBm0
// - Pairs of one low and one high tone
// - Each component within 1.9 percent of nominal
// - Accept power difference of 0 to 10 dB
// - Digit filters when enabled, else skip to tone
// - Valid digit written to digit register
// - Digit raises interrupt, suppresses short-tone flag
// - Latch onset; a digit copies it only when no tone present
// - Envelope smoothing with 32 times decay factor
// - Classify onset, departure, steady tone, silence
// - Departure status and time only after validation
// - Common filter length; width at most 492 Hz
// - Each filter selectable wide or narrow
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module tdfe_top #(
  parameter int DEPTH = 8,
  parameter int NFILT = 6
) (
  input  wire logic                core_clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                sample_valid_in,
  input  wire logic [7:0]          sample_code_in,
  input  wire logic                block_busy_in,
  input  wire logic                first_block_done_in,
  input  wire tdfe_pkg::tdfe_cand_t cand_in,
  input  wire logic [7:0]          addr_in,
  input  wire logic [31:0]         wr_data_in,
  input  wire logic                wr_en_in,
  input  wire logic                rd_en_in,
  output tdfe_pkg::tdfe_proc_t     sample_out,
  output tdfe_pkg::tdfe_class_t    class_out,
  output logic                     class_valid_out,
  output logic [10:0]              flt_len_out,
  output logic [8:0]               flt_width_out,
  output logic [NFILT-1:0]         flt_wide_out,
  output logic [31:0]              rd_data_out,
  output logic                     irq_out
);
  // Parameters the queue pointers can serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || NFILT < 1 || NFILT > 32) begin : g_bad
    $error("tdfe_top: DEPTH must be a power of two, NFILT 1..32");
  end

  localparam int AW = $clog2(DEPTH);

  // Saturate a wide signed value into 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sd32767)       return 16'sh7FFF;
    else if (v < -48'sd32768) return -16'sh8000;
    else                      return v[15:0];
  endfunction : sat16

  // True when freq is within the permitted deviation of nominal
  function automatic logic in_tol(input logic [11:0] f, input logic [11:0] nom);
    logic [15:0] diff;
    diff = (f > nom) ? {4'h0, f - nom} : {4'h0, nom - f};
    return (32'(diff) * 32'(tdfe_pkg::PERMILLE)) <=
           (32'(nom) * 32'(tdfe_pkg::TOL_PERMILLE));
  endfunction : in_tol

  // Expand one companded code to 16-bit linear
  function automatic logic signed [15:0] expand(input logic [7:0] code, input logic mu);
    logic [7:0]  x;
    logic [15:0] mag;
    logic        neg;
    x   = mu ? ~code : code ^ tdfe_pkg::ALAW_XOR;
    neg = mu ? x[7] : ~x[7];
    if (mu)
      mag = 16'(((16'({x[3:0], 3'b000}) + tdfe_pkg::MU_BIAS) << x[6:4]) - tdfe_pkg::MU_BIAS);
    else if (x[6:4] == 3'h0)
      mag = {8'h00, x[3:0], 4'h8};
    else
      mag = 16'((16'({x[3:0], 4'h8}) + tdfe_pkg::ALAW_STEP) << (x[6:4] - 3'h1));
    return neg ? -$signed(mag) : $signed(mag);
  endfunction : expand

  // Sample queue storage and pointers
  logic [7:0]  q_mem [DEPTH];
  logic [AW-1:0] q_wr;
  logic [AW-1:0] q_rd;
  logic [AW:0]   q_cnt;

  // Software settings
  logic [4:0]  ctrl;
  logic [15:0] edf;
  logic [15:0] thr_on;
  logic [15:0] thr_off;
  logic [tdfe_pkg::ST_W-1:0] status;
  logic [tdfe_pkg::ST_W-1:0] mask;

  // Detector state
  logic signed [15:0] envelope_level;
  logic        tone_present;
  logic        onset_valid;
  logic        digit_seen;
  logic [3:0]  digit;
  logic [15:0] cur_time;
  logic [15:0] held_onset;
  logic [15:0] arrival;
  logic [15:0] depart_time;

  // Queue control: a full queue refuses the new code
  wire q_full  = (q_cnt == (AW+1)'(DEPTH));
  wire q_empty = (q_cnt == '0);
  wire push    = sample_valid_in && !q_full;
  wire step    = !q_empty && !block_busy_in;
  wire drop    = sample_valid_in && q_full;

  // Register decode
  wire sel_ctrl   = (addr_in == tdfe_pkg::OFS_CTRL);
  wire sel_edf    = (addr_in == tdfe_pkg::OFS_EDF);
  wire sel_thr_on = (addr_in == tdfe_pkg::OFS_THR_ON);
  wire sel_thr_of = (addr_in == tdfe_pkg::OFS_THR_OFF);
  wire sel_len    = (addr_in == tdfe_pkg::OFS_FLT_LEN);
  wire sel_wid    = (addr_in == tdfe_pkg::OFS_FLT_WID);
  wire sel_fsel   = (addr_in == tdfe_pkg::OFS_FLT_SEL);
  wire sel_stat   = (addr_in == tdfe_pkg::OFS_STATUS);
  wire sel_mask   = (addr_in == tdfe_pkg::OFS_MASK);

  wire mulaw   = ctrl[tdfe_pkg::CTRL_MULAW];
  wire [1:0] gain = ctrl[tdfe_pkg::CTRL_GAIN_L +: 2];
  wire dtmf_en = ctrl[tdfe_pkg::CTRL_DTMF];
  wire tone_en = ctrl[tdfe_pkg::CTRL_TONE];

  // law follows the control bit, A-law after reset
  wire signed [15:0] lin = expand(q_mem[q_rd], mulaw);

  // gain selects the shift; the unused code acts as +2 dBm0
  wire [2:0] gsh = (gain == 2'h1) ? tdfe_pkg::GAIN_SH_M10 :
                   (gain == 2'h2) ? tdfe_pkg::GAIN_SH_M22 : tdfe_pkg::GAIN_SH_P2;
  wire signed [15:0] scaled = sat16(48'(lin) <<< gsh);

  // envelope update, products clamped to 32 bits first
  wire signed [47:0] p_samp = 48'(scaled) * $signed({32'h0000_0000, edf}) <<< tdfe_pkg::ENV_SCALE;
  wire signed [47:0] p_env  = 48'(envelope_level) * $signed({32'h0000_0000, edf})
                              <<< tdfe_pkg::ENV_SCALE;
  wire signed [47:0] a_samp = (p_samp < 0) ? -p_samp : p_samp;
  // hold both products inside the 32-bit range
  wire signed [47:0] c_samp = (a_samp > 48'sh7FFF_FFFF) ? 48'sh7FFF_FFFF : a_samp;
  wire signed [47:0] c_env  = (p_env  > 48'sh7FFF_FFFF) ? 48'sh7FFF_FFFF : p_env;
  wire signed [47:0] e_sum  = (48'(envelope_level) <<< tdfe_pkg::ENV_FRAC) + c_samp - c_env;
  wire signed [15:0] e_raw  = sat16(e_sum >>> tdfe_pkg::ENV_FRAC);
  wire signed [15:0] next_envelope = (e_raw < 0) ? 16'sh0000 : e_raw;

  // four outcomes from the thresholds and the present flag
  wire is_onset  = !tone_present && (next_envelope >= $signed(thr_on));
  wire is_depart = tone_present && (next_envelope < $signed(thr_off));
  wire tdfe_pkg::tdfe_class_t next_class =
      is_onset  ? tdfe_pkg::TDFE_ONSET  :
      is_depart ? tdfe_pkg::TDFE_DEPART :
      tone_present ? tdfe_pkg::TDFE_TONE : tdfe_pkg::TDFE_QUIET;
  wire ev_onset  = step && is_onset;
  wire ev_depart = step && is_depart;

  // locate the row and column of the candidate pair
  logic [3:0] row_hit;
  logic [3:0] col_hit;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // each component inside the deviation window
      row_hit[i] = in_tol(cand_in.low_hz, tdfe_pkg::LOW_HZ[i]);
      col_hit[i] = in_tol(cand_in.high_hz, tdfe_pkg::HIGH_HZ[i]);
    end
  end
  wire [1:0] row = row_hit[3] ? 2'd3 : row_hit[2] ? 2'd2 : row_hit[1] ? 2'd1 : 2'd0;
  wire [1:0] col = col_hit[3] ? 2'd3 : col_hit[2] ? 2'd2 : col_hit[1] ? 2'd1 : 2'd0;
  wire [7:0] spread = (cand_in.low_db > cand_in.high_db) ? cand_in.low_db - cand_in.high_db
                                                        : cand_in.high_db - cand_in.low_db;
  // spread of 0 to 10 dB only
  wire digit_ok = cand_in.valid && dtmf_en && (|row_hit) && (|col_hit) &&
                  (spread <= tdfe_pkg::MAX_SPREAD);

  // Departure outcome: time only after a validated tone or digit
  wire dep_valid = ev_depart && onset_valid;
  // a recognised digit keeps the short-tone flag quiet
  wire dep_short = ev_depart && !onset_valid && tone_en && !digit_seen;
  wire tone_first = first_block_done_in && tone_en && tone_present && !onset_valid;

  // Events into the sticky status bits
  wire [tdfe_pkg::ST_W-1:0] ev;
  assign ev[tdfe_pkg::ST_DIGIT]  = digit_ok;
  assign ev[tdfe_pkg::ST_SHORT]  = dep_short;
  assign ev[tdfe_pkg::ST_DEPART] = dep_valid;
  assign ev[tdfe_pkg::ST_ONSET]  = tone_first;
  assign ev[tdfe_pkg::ST_DROP]   = drop;

  // Clear by writing one; a new event wins over the clear
  wire [tdfe_pkg::ST_W-1:0] w1c = (wr_en_in && sel_stat) ? wr_data_in[tdfe_pkg::ST_W-1:0] : '0;
  wire [tdfe_pkg::ST_W-1:0] next_status = (status & ~w1c) | ev;

  // width requests above the limit are clamped
  wire [8:0] wid_req = (wr_data_in[31:9] != '0 || wr_data_in[8:0] > tdfe_pkg::MAX_FLT_WID)
                       ? tdfe_pkg::MAX_FLT_WID : wr_data_in[8:0];

  // Read multiplexer; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr_in)
      tdfe_pkg::OFS_CTRL:     rd_mux = {27'h0, ctrl};
      tdfe_pkg::OFS_EDF:      rd_mux = {16'h0, edf};
      tdfe_pkg::OFS_THR_ON:   rd_mux = {16'h0, thr_on};
      tdfe_pkg::OFS_THR_OFF:  rd_mux = {16'h0, thr_off};
      tdfe_pkg::OFS_FLT_LEN:  rd_mux = {21'h0, flt_len_out};
      tdfe_pkg::OFS_FLT_WID:  rd_mux = {23'h0, flt_width_out};
      tdfe_pkg::OFS_FLT_SEL:  rd_mux = 32'(flt_wide_out);
      tdfe_pkg::OFS_STATUS:   rd_mux = 32'(status);
      tdfe_pkg::OFS_MASK:     rd_mux = 32'(mask);
      tdfe_pkg::OFS_DIGIT:    rd_mux = {28'h0, digit};
      tdfe_pkg::OFS_ARRIVAL:  rd_mux = {16'h0, arrival};
      tdfe_pkg::OFS_DEPART:   rd_mux = {16'h0, depart_time};
      tdfe_pkg::OFS_CUR_TIME: rd_mux = {16'h0, cur_time};
      tdfe_pkg::OFS_ENVELOPE: rd_mux = {16'h0, envelope_level};
      tdfe_pkg::OFS_STATE:    rd_mux = {24'h0, tone_present, onset_valid, digit_seen,
                                        1'b0, 4'(q_cnt)};
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  // queue write side; storage needs no reset
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      q_mem[q_wr] <= sample_code_in;
    end
  end

  // full queue drops the arrival; write pointer holds, count and read pointer move only on a step
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      q_wr  <= '0;
      q_rd  <= '0;
      q_cnt <= '0;
    end else begin
      q_wr  <= push ? q_wr + 1'b1 : q_wr;
      q_rd  <= step ? q_rd + 1'b1 : q_rd;
      q_cnt <= q_cnt + (AW+1)'(push) - (AW+1)'(step);
    end
  end

  // Host settings; host access is never stalled by block work
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl          <= '0;
      edf           <= tdfe_pkg::RST_EDF;
      thr_on        <= tdfe_pkg::RST_THR_ON;
      thr_off       <= tdfe_pkg::RST_THR_OFF;
      flt_len_out   <= tdfe_pkg::RST_FLT_LEN;
      flt_width_out <= tdfe_pkg::RST_FLT_WID;
      flt_wide_out  <= '0;
      mask          <= '0;
    end else if (wr_en_in) begin
      if (sel_ctrl)   ctrl    <= wr_data_in[4:0];
      if (sel_edf)    edf     <= wr_data_in[15:0];
      if (sel_thr_on) thr_on  <= wr_data_in[15:0];
      if (sel_thr_of) thr_off <= wr_data_in[15:0];
      // one length for all filters, width clamped
      if (sel_len)    flt_len_out   <= wr_data_in[10:0];
      if (sel_wid)    flt_width_out <= wid_req;
      // one wide or narrow bit per filter
      if (sel_fsel)   flt_wide_out  <= wr_data_in[NFILT-1:0];
      if (sel_mask)   mask    <= wr_data_in[tdfe_pkg::ST_W-1:0];
    end
  end

  // Sample path: one step per drained sample
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      envelope_level  <= '0;
      tone_present    <= 1'b0;
      cur_time        <= '0;
      sample_out      <= '0;
      class_out       <= tdfe_pkg::TDFE_QUIET;
      class_valid_out <= 1'b0;
    end else begin
      class_valid_out <= step;
      sample_out.valid <= step;
      if (step) begin
        envelope_level <= next_envelope;
        cur_time       <= cur_time + 16'h0001;
        // route to the digit filters only when enabled
        sample_out.to_dtmf <= dtmf_en;
        sample_out.value   <= scaled;
        class_out          <= next_class;
        if (is_onset)  tone_present <= 1'b1;
        if (is_depart) tone_present <= 1'b0;
      end
    end
  end

  // Digit, timing and validation flags
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      digit       <= '0;
      onset_valid <= 1'b0;
      digit_seen  <= 1'b0;
      held_onset  <= '0;
      arrival     <= '0;
      depart_time <= '0;
    end else begin
      if (ev_onset) held_onset <= cur_time;
      if (digit_ok) begin
        digit       <= {row, col};
        digit_seen  <= 1'b1;
        onset_valid <= 1'b1;
        // arrival loaded only when no tone is reported
        if (!tone_present) arrival <= held_onset;
      end
      if (tone_first) begin
        arrival     <= held_onset;
        onset_valid <= 1'b1;
      end
      if (ev_depart) begin
        if (onset_valid) depart_time <= cur_time;
        onset_valid <= 1'b0;
        digit_seen  <= 1'b0;
      end
    end
  end

  // Status, interrupt line and registered read data
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      status      <= '0;
      irq_out     <= 1'b0;
      rd_data_out <= '0;
    end else begin
      status      <= next_status;
      irq_out     <= |(next_status & mask);
      rd_data_out <= rd_en_in ? rd_mux : 32'h0000_0000;
    end
  end

  chk_queue_bound: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    q_cnt <= (AW+1)'(DEPTH)) else $error("queue count above depth");

  // a refused arrival leaves the count unchanged
  chk_full_drop: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (drop && !step) |=> (q_cnt == $past(q_cnt) && status[tdfe_pkg::ST_DROP]))
    else $error("full queue did not drop the sample");

  // nothing drains while block work runs
  chk_block_pause: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (block_busy_in && !sys_rst_in) |=> !class_valid_out) else $error("step during block work");

  // envelope stays within the non-negative 16-bit range
  chk_env_range: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    envelope_level >= 0) else $error("envelope went negative");

  // accepted digit raises its status and the line if unmasked
  chk_digit_irq: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (digit_ok && mask[tdfe_pkg::ST_DIGIT]) |=> (status[tdfe_pkg::ST_DIGIT] && irq_out))
    else $error("digit did not raise interrupt");

  // departure after a digit never flags a short tone
  chk_short_suppress: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (ev_depart && digit_seen && !status[tdfe_pkg::ST_SHORT]) |=> !status[tdfe_pkg::ST_SHORT])
    else $error("short tone flagged after digit");

  // passband width never exceeds its limit
  chk_width_limit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    flt_width_out <= tdfe_pkg::MAX_FLT_WID) else $error("filter width above limit");

  // digit during a present tone leaves arrival alone
  chk_arrival_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (digit_ok && tone_present && !tone_first) |=> $stable(arrival))
    else $error("arrival overwritten while tone present");

  // departure flag only follows a validated onset
  chk_depart_valid: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(status[tdfe_pkg::ST_DEPART]) |-> $past(onset_valid) && $past(ev_depart))
    else $error("departure flagged without validation");

  // onset class always follows an envelope crossing
  chk_onset_class: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (class_valid_out && class_out == tdfe_pkg::TDFE_ONSET) |-> tone_present &&
    (envelope_level >= $signed(thr_on))) else $error("onset without crossing");
endmodule : tdfe_top

// *** tb/tdfe_codec_model.sv ***
// Codec side model: sends companded codes, one per clock, on request.
// Assumes send is called from the bench clock domain.
`timescale 1ns/100ps
module tdfe_codec_model (
  input  wire logic  clk_in,
  output logic       valid_out,
  output logic [7:0] code_out
);
  // Line starts idle
  initial begin
    valid_out <= 1'b0;
    code_out  <= 8'h00;
  end

  // Burst of n equal codes; afterwards the line shows the inverse
  // so that a stale code can never pass for a fresh one
  task automatic send(input int n, input logic [7:0] code);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      valid_out <= 1'b1;
      code_out  <= code;
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    code_out  <= ~code;
  endtask : send
endmodule : tdfe_codec_model

// *** tb/test_tone_detector_front_end.sv ***
// Self-checking bench: register port, sample queue and digit check.
// Assumes the design answers reads one cycle after the strobe.
`timescale 1ns/100ps
module test_tone_detector_front_end;
  logic                 clk = 1'b0;  // Core clock, 100 ns
  logic                 rst = 1'b1;  // Synchronous reset
  logic                 s_vld;       // Codec strobe from model
  logic [7:0]           s_code;      // Codec code from model
  logic                 busy = 1'b0; // End-of-block stall
  logic                 fbd = 1'b0;  // First block done
  tdfe_pkg::tdfe_cand_t cand = '0;   // Digit candidate
  logic [7:0]           addr = 8'h00;
  logic [31:0]          wdat = 32'h0000_0000;
  logic                 wen = 1'b0;
  logic                 ren = 1'b0;
  tdfe_pkg::tdfe_proc_t smp;         // Processed sample
  logic [31:0]          rdat;
  logic [5:0]           wide;
  logic [8:0]           fwid;
  logic [10:0]          flen;
  logic                 irq;
  logic [3:0]           cls;         // Power detector outcome
  logic                 cvld;        // Outcome strobe
  int                   classes = 0; // Outcome strobes seen
  int                   err_total = 0;
  int                   compares = 0;
  int                   cycles = 0;
  int                   drained = 0; // Samples seen leaving
  logic [31:0]          d;

  always #50 clk = ~clk;

  tdfe_codec_model i_tdfe_codec_model (.clk_in(clk), .valid_out(s_vld), .code_out(s_code));

  tdfe_top i_tdfe_top (
    .core_clk_in(clk), .sys_rst_in(rst), .sample_valid_in(s_vld),
    .sample_code_in(s_code), .block_busy_in(busy), .first_block_done_in(fbd),
    .cand_in(cand), .addr_in(addr), .wr_data_in(wdat), .wr_en_in(wen),
    .rd_en_in(ren), .sample_out(smp), .class_out(cls), .class_valid_out(cvld),
    .flt_len_out(flen), .flt_width_out(fwid), .flt_wide_out(wide),
    .rd_data_out(rdat), .irq_out(irq)
  );

  // Count drained samples; a hang is cut short by the cycle ceiling
  always @(posedge clk) begin
    cycles++;
    if (smp.valid === 1'b1) begin
      drained++;
    end
    if (cvld === 1'b1) begin
      classes++;
    end
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wen  <= 1'b1;
    addr <= a;
    wdat <= v;
    @(posedge clk);
    wen <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    ren  <= 1'b1;
    addr <= a;
    @(posedge clk);
    ren <= 1'b0;
    #1;
    chk(rdat & m, e);
  endtask : rchk

  // One candidate pulse, then time for status to settle
  task automatic dig(input logic [11:0] lo, input logic [11:0] hi, input logic [7:0] ldb);
    @(posedge clk);
    cand <= '{1'b1, lo, hi, ldb, 8'h1E};
    @(posedge clk);
    cand.valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : dig

  task automatic end_of_test;
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  localparam logic [31:0] ALL = 32'hFFFF_FFFF;

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk(tdfe_pkg::OFS_EDF, ALL, 32'h0000_0040);
    rchk(tdfe_pkg::OFS_FLT_LEN, ALL, 32'h0000_003D);
    chk({21'h0, flen}, 32'h0000_003D);
    rchk(8'h3C, ALL, 32'h0000_0000);
    wr(tdfe_pkg::OFS_FLT_WID, 32'h0000_01FF);
    rchk(tdfe_pkg::OFS_FLT_WID, ALL, 32'h0000_01EC);
    chk({23'h0, fwid}, 32'h0000_01EC);
    wr(tdfe_pkg::OFS_FLT_SEL, 32'h0000_002A);
    #1;
    chk({26'h0, wide}, 32'h0000_002A);
    // Queue fills to eight while stalled, ninth is dropped
    wr(tdfe_pkg::OFS_MASK, 32'h0000_0011);
    busy <= 1'b1;
    i_tdfe_codec_model.send(9, 8'hD5);
    rchk(tdfe_pkg::OFS_STATE, 32'h0000_000F, 32'h0000_0008);
    rchk(tdfe_pkg::OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    chk({31'h0, irq}, 32'h0000_0001);
    chk(drained, 0);
    @(posedge clk);
    busy <= 1'b0;
    for (int i = 0; i < 40 && drained < 8; i++) @(posedge clk);
    chk(drained, 8);
    rchk(tdfe_pkg::OFS_CUR_TIME, ALL, 32'h0000_0008);
    wr(tdfe_pkg::OFS_STATUS, 32'h0000_0010);
    rchk(tdfe_pkg::OFS_STATUS, ALL, 32'h0000_0000);
    // mu-law zero code, digit receiver on
    wr(tdfe_pkg::OFS_CTRL, 32'h0000_0009);
    i_tdfe_codec_model.send(1, 8'hFF);
    for (int i = 0; i < 40 && drained < 9; i++) @(posedge clk);
    chk({15'h0, smp.to_dtmf, smp.value}, 32'h0001_0000);
    // Digit validation: boundaries of tolerance and power spread
    wr(tdfe_pkg::OFS_MASK, 32'h0000_0001);
    dig(12'd785, 12'd1336, 8'd20);
    rchk(tdfe_pkg::OFS_STATUS, ALL, 32'h0000_0000);
    dig(12'd770, 12'd1336, 8'd19);
    rchk(tdfe_pkg::OFS_STATUS, ALL, 32'h0000_0000);
    dig(12'd784, 12'd1336, 8'd20);
    rchk(tdfe_pkg::OFS_DIGIT, ALL, 32'h0000_0005);
    rchk(tdfe_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    dig(12'd941, 12'd1633, 8'd30);
    rchk(tdfe_pkg::OFS_DIGIT, ALL, 32'h0000_000F);
    wr(tdfe_pkg::OFS_STATUS, 32'h0000_001F);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    // Decay factor of one: the envelope takes the sample's magnitude
    wr(tdfe_pkg::OFS_EDF, 32'h0000_0400);
    wr(tdfe_pkg::OFS_CTRL, 32'h0000_0019);
    // Onset, then a departure validated by the earlier digit
    i_tdfe_codec_model.send(1, 8'h80);
    rchk(tdfe_pkg::OFS_STATE, 32'h0000_00E0, 32'h0000_00E0);
    chk({28'h0, cls}, 32'h0000_0001);
    rchk(tdfe_pkg::OFS_ENVELOPE, ALL, 32'h0000_7D7C);
    i_tdfe_codec_model.send(1, 8'hFF);
    rchk(tdfe_pkg::OFS_STATUS, ALL, 32'h0000_0004);
    rchk(tdfe_pkg::OFS_DEPART, ALL, 32'h0000_000A);
    chk({28'h0, cls}, 32'h0000_0002);
    // First filter block validates a fresh tone and loads its arrival
    wr(tdfe_pkg::OFS_STATUS, 32'h0000_001F);
    i_tdfe_codec_model.send(1, 8'h80);
    @(posedge clk);
    fbd <= 1'b1;
    @(posedge clk);
    fbd <= 1'b0;
    rchk(tdfe_pkg::OFS_ARRIVAL, ALL, 32'h0000_000B);
    i_tdfe_codec_model.send(1, 8'hFF);
    rchk(tdfe_pkg::OFS_STATUS, ALL, 32'h0000_000C);
    // Unvalidated tone: short-tone flag, departure time kept
    i_tdfe_codec_model.send(1, 8'h80);
    i_tdfe_codec_model.send(1, 8'hFF);
    rchk(tdfe_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    rchk(tdfe_pkg::OFS_DEPART, ALL, 32'h0000_000C);
    // A-law code of value 8 under gain codes 2 and 1, digit path off
    wr(tdfe_pkg::OFS_CTRL, 32'h0000_0004);
    i_tdfe_codec_model.send(1, 8'hD5);
    rchk(tdfe_pkg::OFS_ENVELOPE, ALL, 32'h0000_0080);
    wr(tdfe_pkg::OFS_CTRL, 32'h0000_0002);
    i_tdfe_codec_model.send(1, 8'hD5);
    rchk(tdfe_pkg::OFS_ENVELOPE, ALL, 32'h0000_0020);
    chk({15'h0, smp.to_dtmf, smp.value}, 32'h0000_0020);
    chk(drained, 17);
    chk(classes, 17);
    end_of_test();
  end
endmodule : test_tone_detector_front_end
